//--- logic/conv_pkg.sv
/*
  Shared constants and types for the four-channel sample/convert/readout control.
  Assumes a 125 MHz system clock; all timing counts are derived from it here.
*/
package conv_pkg;

  // ----------------------------------------------------------------
  // Data path shape
  // ----------------------------------------------------------------
  localparam int DATA_W = 12; // Result width
  localparam int CHANNELS = 4; // Track/hold channels
  localparam int CH_W = 2; // Channel index width
  localparam int FIFO_DEPTH = 32; // Result buffer depth
  localparam logic [CH_W-1:0] CH_FIRST = 2'h0;
  localparam logic [CH_W-1:0] CH_LAST = 2'h3;

  // ----------------------------------------------------------------
  // Successive approximation sequence
  // ----------------------------------------------------------------
  localparam int SETTLE_TICKS = 7; // Conversion clock edges per channel settle
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] BIT_TOP = 4'hB;      // First trial bit (MSB)
  localparam logic [DATA_W-1:0] TRIAL_MSB = 12'h800;
  localparam logic [DATA_W-1:0] SIGN_FLIP = 12'h800;   // Offset binary to two's complement
  localparam logic [DATA_W-1:0] DATA_IDLE = 12'h000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8; // System clock period
  localparam int INT_OSC_PERIOD_NS = 400; // Internal conversion clock period
  localparam int INT_OSC_DIV = (INT_OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIV_W = 6;
  localparam logic [DIV_W-1:0] DIV_ZERO = 6'h00;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(INT_OSC_DIV - 1);

  // ----------------------------------------------------------------
  // Pin synchroniser slots
  // ----------------------------------------------------------------
  localparam int SYNC_N = 6;
  localparam int SY_TRIG = 0;
  localparam int SY_CS = 1;
  localparam int SY_RD = 2;
  localparam int SY_CLK = 3;
  localparam int SY_OSC = 4;
  localparam int SY_CMP = 5;

  // Sequencer states, Gray coded along the usual path
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_START = 3'h1,
    S_SETTLE = 3'h3,
    S_TRIAL = 3'h2,
    S_STORE = 3'h6,
    S_FINISH = 3'h7
  } sar_state_e;

endpackage : conv_pkg

//--- logic/stream_if.sv
/*
  Valid/ready word stream between the sequencer, the result buffer and the read port.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps

interface stream_if #(parameter int W = 12);
  logic valid;            // Word offered
  logic ready;            // Word taken when both high
  logic [W-1:0] data;     // Word

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : stream_if

//--- logic/sample_fifo.sv
/*
  Result buffer: flip-flop FIFO with valid/ready on both sides and a flush.
  Assumes DEPTH is a power of two so pointers wrap naturally.
*/
`timescale 1ns/1ps

module sample_fifo #(
  parameter int W = 12,
  parameter int DEPTH = 32
) (
  // Clock and control
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic flush,
  // Streams
  stream_if.snk fill,
  stream_if.src drain
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
  localparam logic [AW:0] CNT_EMPTY = '0;

  logic [W-1:0] mem_ff [DEPTH];   // Storage
  logic [AW-1:0] wr_ptr_ff;       // Next write slot
  logic [AW-1:0] rd_ptr_ff;       // Head slot
  logic [AW:0] count_ff;          // Words held
  logic push;
  logic pop;

  // ----------------------------------------------------------------
  // Handshakes
  // ----------------------------------------------------------------
  assign fill.ready = (count_ff != CNT_FULL);
  assign drain.valid = (count_ff != CNT_EMPTY);
  assign drain.data = mem_ff[rd_ptr_ff];
  assign push = fill.valid & fill.ready;
  assign pop = drain.valid & drain.ready;

  // Storage write
  always_ff @(posedge clock) begin
    if (clk_en && push && !flush) begin
      mem_ff[wr_ptr_ff] <= fill.data;
    end
  end

  // Pointers and fill level; flush empties the buffer
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= CNT_EMPTY;
    end else if (clk_en) begin
      if (flush) begin
        wr_ptr_ff <= '0;
        rd_ptr_ff <= '0;
        count_ff <= CNT_EMPTY;
      end else begin
        wr_ptr_ff <= wr_ptr_ff + AW'(push);
        rd_ptr_ff <= rd_ptr_ff + AW'(pop);
        count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
      end
    end
  end

endmodule : sample_fifo

//--- logic/sar_sequencer.sv
/*
  Four-channel successive approximation sequencer.
  Assumes conv_tick is a one-cycle pulse per conversion clock rising edge and
  comparator_high is already synchronised.
*/
`timescale 1ns/1ps

module sar_sequencer #(
  parameter int SETTLE = conv_pkg::SETTLE_TICKS
) (
  // Clock and control
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic start,
  input wire logic conv_tick,
  // Analog front end
  input wire logic comparator_high,
  output logic [conv_pkg::CH_W-1:0] mux_select,
  output logic [conv_pkg::DATA_W-1:0] dac_code,
  // Status
  output logic busy,
  output logic seq_done,
  // Results
  stream_if.src result
);

  localparam logic [3:0] SETTLE_LAST = 4'(SETTLE - 1);

  conv_pkg::sar_state_e state_ff, nxt_state;
  logic [conv_pkg::CH_W-1:0] ch_ff, nxt_ch;        // Channel in conversion
  logic [3:0] cnt_ff, nxt_cnt;                     // Settle count or trial bit
  logic [conv_pkg::DATA_W-1:0] code_ff, nxt_code;  // Trial code, offset binary

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign mux_select = ch_ff;
  assign dac_code = code_ff;
  assign busy = (state_ff != conv_pkg::S_IDLE);
  assign seq_done = (state_ff == conv_pkg::S_FINISH) & conv_tick & ~start;
  assign result.valid = (state_ff == conv_pkg::S_STORE);
  assign result.data = code_ff ^ conv_pkg::SIGN_FLIP;

  // Next state: start restarts at channel one from any state
  always_comb begin
    nxt_state = state_ff;
    nxt_ch = ch_ff;
    nxt_cnt = cnt_ff;
    nxt_code = code_ff;
    if (start) begin
      nxt_state = conv_pkg::S_START;
      nxt_ch = conv_pkg::CH_FIRST;
      nxt_cnt = conv_pkg::CNT_ZERO;
      nxt_code = conv_pkg::DATA_IDLE;
    end else begin
      case (state_ff)
        // First tick aligns the asynchronous trigger with the clock
        conv_pkg::S_START: begin
          if (conv_tick) begin
            nxt_state = conv_pkg::S_SETTLE;
          end
        end
        // Let the multiplexer settle on the held channel
        conv_pkg::S_SETTLE: begin
          if (conv_tick) begin
            if (cnt_ff == SETTLE_LAST) begin
              nxt_state = conv_pkg::S_TRIAL;
              nxt_cnt = conv_pkg::BIT_TOP;
              nxt_code = conv_pkg::TRIAL_MSB;
            end else begin
              nxt_cnt = cnt_ff + conv_pkg::CNT_ONE;
            end
          end
        end
        // One bit decided per tick, MSB first
        conv_pkg::S_TRIAL: begin
          if (conv_tick) begin
            if (!comparator_high) begin
              nxt_code[cnt_ff] = 1'b0;
            end
            if (cnt_ff == conv_pkg::CNT_ZERO) begin
              nxt_state = conv_pkg::S_STORE;
            end else begin
              nxt_code[cnt_ff - conv_pkg::CNT_ONE] = 1'b1;
              nxt_cnt = cnt_ff - conv_pkg::CNT_ONE;
            end
          end
        end
        // Hand the result to the buffer, stall while it is full
        conv_pkg::S_STORE: begin
          if (result.ready) begin
            if (ch_ff == conv_pkg::CH_LAST) begin
              nxt_state = conv_pkg::S_FINISH;
            end else begin
              nxt_state = conv_pkg::S_SETTLE;
              nxt_ch = ch_ff + 2'h1;
              nxt_cnt = conv_pkg::CNT_ZERO;
            end
          end
        end
        // Closing tick, completion flagged here
        conv_pkg::S_FINISH: begin
          if (conv_tick) begin
            nxt_state = conv_pkg::S_IDLE;
          end
        end
        default: begin
          nxt_state = conv_pkg::S_IDLE;
        end
      endcase
    end
  end

  // State registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= conv_pkg::S_IDLE;
      ch_ff <= conv_pkg::CH_FIRST;
      cnt_ff <= conv_pkg::CNT_ZERO;
      code_ff <= conv_pkg::DATA_IDLE;
    end else if (clk_en) begin
      state_ff <= nxt_state;
      ch_ff <= nxt_ch;
      cnt_ff <= nxt_cnt;
      code_ff <= nxt_code;
    end
  end

endmodule : sar_sequencer

//--- logic/adc_control.sv
/*
  Top of the four-channel sample/convert/readout control: pin synchronisers,
  conversion clock selection, track/hold control, completion flag and the
  sequential read port onto a three-state result bus.
  Assumes an external pad resolves sample_data_bus from its output enable and
  that the comparator and conversion clock pins are asynchronous to clock.
*/
// How it works
// - trigger rise holds all channels, starts conversion
// - channels converted one to four in order
// - trigger taken asynchronously, ignoring select and read
// - data bus driven while select and read low, released two clock edges after either rises
// - four reads return channels one to four
// - select active low gates all read strobes
// - external conversion clock, or internal oscillator when off
// - done flag low means results are available
// - done falling returns all stages to track
// - results two's complement, bit eleven most significant
// - done low only after four results stored
// - sequence takes 78 or 79 conversion clock edges
// - no direct result selection, sequential reads only
`timescale 1ns/1ps

module adc_control #(
  parameter int FIFO_DEPTH = conv_pkg::FIFO_DEPTH
) (
  // Clock, reset, enable
  input wire logic clock,
  input wire logic nrst,
  input wire logic clk_en,
  // Host bus pins
  input wire logic conversion_trigger,
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  output logic [conv_pkg::DATA_W-1:0] sample_data_bus_o,
  output logic sample_data_bus_oe,
  output logic conversion_done_n,
  // Conversion clock pin and its tied-off detection
  input wire logic conv_clock_pin,
  input wire logic conv_clock_pin_off,
  // Analog front end
  input wire logic comparator_high,
  output logic track_hold_hold,
  output logic [conv_pkg::CH_W-1:0] mux_select,
  output logic [conv_pkg::DATA_W-1:0] dac_code
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_ff;    // First reset stage
  logic rst_sync_ff;    // Released reset used everywhere
  logic rst_n;

  // Reset asserts at once, releases after two edges
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  assign rst_n = rst_sync_ff;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [conv_pkg::SYNC_N-1:0] pin_raw;      // Asynchronous pin levels
  logic [conv_pkg::SYNC_N-1:0] sync_meta_ff; // First stage, read by second only
  logic [conv_pkg::SYNC_N-1:0] sync_ff;      // Safe pin levels

  assign pin_raw[conv_pkg::SY_TRIG] = conversion_trigger;
  assign pin_raw[conv_pkg::SY_CS] = chip_select_n;
  assign pin_raw[conv_pkg::SY_RD] = read_strobe_n;
  assign pin_raw[conv_pkg::SY_CLK] = conv_clock_pin;
  assign pin_raw[conv_pkg::SY_OSC] = conv_clock_pin_off;
  assign pin_raw[conv_pkg::SY_CMP] = comparator_high;

  // Two flip-flops per pin; strobes idle high
  genvar gi;
  generate
    for (gi = 0; gi < conv_pkg::SYNC_N; gi++) begin : g_sync
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          sync_meta_ff[gi] <= 1'b1;
          sync_ff[gi] <= 1'b1;
        end else if (clk_en) begin
          sync_meta_ff[gi] <= pin_raw[gi];
          sync_ff[gi] <= sync_meta_ff[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  logic trig_d_ff;      // Trigger one cycle back
  logic clk_d_ff;       // Conversion clock pin one cycle back
  logic rd_act_d_ff;    // Read access one cycle back
  logic trig_rise;      // Trigger low to high
  logic ext_rise;       // External conversion clock rising edge
  logic rd_act;         // Selected read in progress
  logic rd_start;       // First cycle of a read

  assign trig_rise = sync_ff[conv_pkg::SY_TRIG] & ~trig_d_ff;
  assign ext_rise = sync_ff[conv_pkg::SY_CLK] & ~clk_d_ff;
  assign rd_act = ~sync_ff[conv_pkg::SY_CS] & ~sync_ff[conv_pkg::SY_RD];
  assign rd_start = rd_act & ~rd_act_d_ff;

  // Previous levels for the edge detectors
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      trig_d_ff <= 1'b1;
      clk_d_ff <= 1'b1;
      rd_act_d_ff <= 1'b0;
    end else if (clk_en) begin
      trig_d_ff <= sync_ff[conv_pkg::SY_TRIG];
      clk_d_ff <= sync_ff[conv_pkg::SY_CLK];
      rd_act_d_ff <= rd_act;
    end
  end

  // ----------------------------------------------------------------
  // Conversion clock
  // ----------------------------------------------------------------
  logic [conv_pkg::DIV_W-1:0] div_ff;   // Internal oscillator divider
  logic osc_tick;                       // Internal oscillator edge
  logic conv_tick;                      // Selected conversion clock edge

  assign osc_tick = (div_ff == conv_pkg::DIV_LAST);
  assign conv_tick = sync_ff[conv_pkg::SY_OSC] ? osc_tick : ext_rise;

  // Free running divider standing in for the internal oscillator
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_ff <= conv_pkg::DIV_ZERO;
    end else if (clk_en) begin
      div_ff <= osc_tick ? conv_pkg::DIV_ZERO : div_ff + 6'h01;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer and result buffer
  // ----------------------------------------------------------------
  stream_if #(.W(conv_pkg::DATA_W)) to_buf ();
  stream_if #(.W(conv_pkg::DATA_W)) from_buf ();
  logic seq_done;     // Fourth result stored, sequence closed

  // Converts the held channels; a trigger restarts it
  sar_sequencer #(
    .SETTLE(conv_pkg::SETTLE_TICKS)
  ) u_seq (
    .clock(clock),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .start(trig_rise),
    .conv_tick(conv_tick),
    .comparator_high(sync_ff[conv_pkg::SY_CMP]),
    .mux_select(mux_select),
    .dac_code(dac_code),
    .busy(),
    .seq_done(seq_done),
    .result(to_buf.src)
  );

  // Results wait here in channel order; a trigger flushes them
  sample_fifo #(
    .W(conv_pkg::DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_buf (
    .clock(clock),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .flush(trig_rise),
    .fill(to_buf.snk),
    .drain(from_buf.src)
  );

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  logic [conv_pkg::DATA_W-1:0] data_ff;   // Word on the bus

  // Each read takes the head word, so order is the only way in
  assign from_buf.ready = rd_start;

  // Capture the next result at the start of each read
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      data_ff <= conv_pkg::DATA_IDLE;
    end else if (clk_en && rd_start) begin
      data_ff <= from_buf.valid ? from_buf.data : conv_pkg::DATA_IDLE;
    end
  end

  assign sample_data_bus_o = data_ff;
  assign sample_data_bus_oe = rd_act & rd_act_d_ff;

  // ----------------------------------------------------------------
  // Completion flag and track/hold
  // ----------------------------------------------------------------
  logic done_n_ff;    // Results ready, active low
  logic hold_ff;      // Track/hold stages in hold

  // Completion wins over a read in the same cycle; a trigger in that cycle suppresses completion
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      done_n_ff <= 1'b1;
    end else if (clk_en) begin
      if (seq_done) begin
        done_n_ff <= 1'b0;
      end else if (rd_start || trig_rise) begin
        done_n_ff <= 1'b1;
      end
    end
  end

  // Hold from the trigger until completion is flagged
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hold_ff <= 1'b0;
    end else if (clk_en) begin
      if (trig_rise) begin
        hold_ff <= 1'b1;
      end else if (seq_done) begin
        hold_ff <= 1'b0;
      end
    end
  end

  assign conversion_done_n = done_n_ff;
  assign track_hold_hold = hold_ff;

endmodule : adc_control

//--- tb/adc_control_chk.sv
/*
  Bound checker for adc_control: bus gating, conversion timing and completion flag.
  Assumes clk_en stays high and the conversion clock source is fixed per conversion.
*/
`timescale 1ns/1ps

module adc_control_chk #(
  parameter int FIFO_DEPTH = conv_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Host bus pins
  input wire logic conversion_trigger,
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic [conv_pkg::DATA_W-1:0] sample_data_bus_o,
  input wire logic sample_data_bus_oe,
  input wire logic conversion_done_n,
  // Conversion clock pin
  input wire logic conv_clock_pin,
  input wire logic conv_clock_pin_off,
  // Analog front end
  input wire logic track_hold_hold,
  input wire logic [conv_pkg::CH_W-1:0] mux_select
);
  // ----------------------------------------------------------------
  // Conversion clock edges since the last trigger rise
  // ----------------------------------------------------------------
  logic trig_d_ff; // Trigger one cycle ago
  logic pin_d_ff; // Clock pin one cycle ago
  logic [7:0] edges_ff; // Rising pin edges seen
  wire trig_edge = conversion_trigger & ~trig_d_ff;
  wire pin_edge = conv_clock_pin & ~pin_d_ff & (edges_ff != 8'hFF);
  wire [7:0] nxt_edges = trig_edge ? 8'h00 : edges_ff + {7'h00, pin_edge};

  // Count restarts at every trigger rise and saturates
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      trig_d_ff <= 1'b1;
      pin_d_ff <= 1'b0;
      edges_ff <= 8'h00;
    end else begin
      trig_d_ff <= conversion_trigger;
      pin_d_ff <= conv_clock_pin;
      edges_ff <= nxt_edges;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence trig_begin; $rose(conversion_trigger); endsequence
  sequence read_begin; $fell(chip_select_n | read_strobe_n); endsequence
  sequence done_fall; $fell(conversion_done_n); endsequence

  a_bus_gate_select: assert property (
    sample_data_bus_oe |-> !$past(chip_select_n, 2) && !$past(read_strobe_n, 2))
    else $error("bus driven unselected");
  a_bus_release: assert property (
    (chip_select_n || read_strobe_n) [*3] |-> !sample_data_bus_oe)
    else $error("bus not released");
  a_data_held: assert property (
    sample_data_bus_oe && $past(sample_data_bus_oe) |-> $stable(sample_data_bus_o))
    else $error("bus data changed");
  a_trig_starts_hold: assert property (
    trig_begin |-> ##[2:4] (track_hold_hold && conversion_done_n))
    else $error("trigger ignored");
  a_mux_in_order: assert property (
    track_hold_hold && $past(track_hold_hold) && $changed(mux_select) |->
      mux_select == $past(mux_select) + 2'h1 || mux_select == conv_pkg::CH_FIRST)
    else $error("channel order broken");
  a_track_on_done: assert property (
    done_fall |-> $fell(track_hold_hold)) else $error("stages not back to track");
  a_hold_until_done: assert property (
    $fell(track_hold_hold) |-> done_fall) else $error("hold left before done");
  a_conv_length: assert property (
    done_fall ##0 !conv_clock_pin_off |-> edges_ff >= 8'h4E && edges_ff <= 8'h4F)
    else $error("conversion length wrong");
  a_done_release: assert property (
    read_begin |-> ##[2:4] conversion_done_n) else $error("done not released by read");
endmodule : adc_control_chk

bind adc_control adc_control_chk #(.FIFO_DEPTH(FIFO_DEPTH)) adc_control_chk_inst (
  .clock(clock), .nrst(nrst), .conversion_trigger(conversion_trigger),
  .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
  .sample_data_bus_o(sample_data_bus_o), .sample_data_bus_oe(sample_data_bus_oe),
  .conversion_done_n(conversion_done_n), .conv_clock_pin(conv_clock_pin),
  .conv_clock_pin_off(conv_clock_pin_off), .track_hold_hold(track_hold_hold),
  .mux_select(mux_select));

//--- tb/analog_front_model.sv
/*
  Analog front end stand-in: four track/hold stages, multiplexer and comparator.
  Assumes the bench supplies live input codes in offset binary.
*/
`timescale 1ns/1ps

module analog_front_model (
  // Clock
  input wire logic clock,
  // Live inputs from the bench
  input wire logic [11:0] live_code [4],
  // Device side
  input wire logic track_hold_hold,
  input wire logic [1:0] mux_select,
  input wire logic [11:0] dac_code,
  output logic comparator_high
);
  logic hold_d = 1'b0; // Hold one cycle ago
  logic [1:0] mux_d = 2'h0; // Channel one cycle ago
  logic [11:0] held [4] = '{4{12'h000}}; // Held input codes

  // Stages freeze on hold entry or on a restart at channel one
  always @(posedge clock) begin
    hold_d <= track_hold_hold;
    mux_d <= mux_select;
    if (track_hold_hold && (!hold_d || (mux_select == 2'h0 && mux_d != 2'h0))) begin
      held <= live_code;
    end
  end

  // Trial bit kept while the held input is at or above the trial code
  assign comparator_high = (held[mux_select] >= dac_code);
endmodule : analog_front_model

//--- tb/tb.sv
/*
  Self-checking bench for adc_control: conversions, reads, restarts, clock sources.
  Assumes the analog model and the bound checker are compiled with it.
*/
`timescale 1ns/1ps

module tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic clk_en = 1'b1; // Runs throughout
  logic conversion_trigger = 1'b0;
  logic chip_select_n = 1'b1;
  logic read_strobe_n = 1'b1;
  logic ext_on = 1'b1; // External conversion clock running
  logic conv_clock_pin_off = 1'b0;
  logic [3:0] div = 4'h0; // Conversion clock divider
  logic [11:0] live [4]; // Live analog codes
  logic [11:0] exp_code [4]; // Codes held at the trigger
  logic [11:0] word;
  wire conv_clock_pin = ext_on & div[3];
  wire comparator_high, track_hold_hold, sample_data_bus_oe, conversion_done_n;
  wire [1:0] mux_select;
  wire [11:0] dac_code, sample_data_bus_o;
  integer seed = 32'h49FF;
  int bad_count = 0;
  int checked = 0;

  // Clock and a 16-cycle external conversion clock
  initial begin
    forever #4 clock = ~clock;
  end
  always @(negedge clock) div <= div + 4'h1;

  adc_control adc_control_inst (.clock(clock), .nrst(nrst), .clk_en(clk_en),
    .conversion_trigger(conversion_trigger), .chip_select_n(chip_select_n),
    .read_strobe_n(read_strobe_n), .sample_data_bus_o(sample_data_bus_o),
    .sample_data_bus_oe(sample_data_bus_oe), .conversion_done_n(conversion_done_n),
    .conv_clock_pin(conv_clock_pin), .conv_clock_pin_off(conv_clock_pin_off),
    .comparator_high(comparator_high), .track_hold_hold(track_hold_hold),
    .mux_select(mux_select), .dac_code(dac_code));
  analog_front_model analog_front_model_inst (.clock(clock), .live_code(live),
    .track_hold_hold(track_hold_hold), .mux_select(mux_select), .dac_code(dac_code),
    .comparator_high(comparator_high));

  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  // Offset binary code to two's complement
  function automatic logic [11:0] exp_word(input logic [11:0] code);
    return code ^ 12'h800;
  endfunction : exp_word

  task automatic cmp_word(input string what, input logic [11:0] e, input logic [11:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : cmp_word

  task automatic cmp_bit(input string what, input logic e, input logic g);
    cmp_word(what, {11'h000, e}, {11'h000, g});
  endtask : cmp_bit

  task automatic give_verdict;
    $display("counts: checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict

  // Conditions waited on: 0 held at channel one, 1 done, 2 bus driven
  function automatic logic cond(input int sel);
    case (sel)
      0: return track_hold_hold === 1'b1 && mux_select === 2'h0;
      1: return conversion_done_n === 1'b0;
      default: return sample_data_bus_oe === 1'b1;
    endcase
  endfunction : cond

  // Bounded wait; running out ends the run
  task automatic wait_on(input int sel, input int bound);
    int n;
    n = 0;
    while (!cond(sel)) begin
      @(negedge clock);
      n++;
      if (n > bound) begin
        cmp_bit("bounded wait", 1'b1, 1'b0);
        give_verdict();
      end
    end
  endtask : wait_on

  // Trigger at a random phase; inputs move well after the hold
  task automatic start_conv;
    repeat ($random(seed) & 15) @(negedge clock);
    conversion_trigger = 1'b1;
    wait_on(0, 8);
    exp_code = live;
    repeat (8) @(negedge clock);
    foreach (live[i]) live[i] = 12'($random(seed));
    conversion_trigger = 1'b0;
  endtask : start_conv

  task automatic finish_conv;
    wait_on(1, 6000);
    cmp_bit("hold at done", 1'b0, track_hold_hold);
  endtask : finish_conv

  // One read: strobes low until the bus is driven
  task automatic read_word(output logic [11:0] d);
    @(negedge clock);
    chip_select_n = 1'b0;
    read_strobe_n = 1'b0;
    wait_on(2, 8);
    d = sample_data_bus_o;
    @(negedge clock);
    chip_select_n = 1'b1;
    read_strobe_n = 1'b1;
    repeat (4) @(negedge clock);
  endtask : read_word

  task automatic read_check(input int n);
    for (int i = 0; i < n; i++) begin
      read_word(word);
      cmp_word("channel result", exp_word(exp_code[i]), word);
      cmp_bit("done released", 1'b1, conversion_done_n);
      cmp_bit("bus released", 1'b0, sample_data_bus_oe);
    end
  endtask : read_check

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    live = '{12'h000, 12'hFFF, 12'h800, 12'h7FF};
    repeat (8) @(negedge clock);
    nrst = 1'b1;
    repeat (4) @(negedge clock);
    cmp_bit("reset done flag", 1'b1, conversion_done_n);
    cmp_bit("reset hold", 1'b0, track_hold_hold);
    cmp_bit("reset bus enable", 1'b0, sample_data_bus_oe);
    // Corner codes, a strobe without select, then an over-read
    start_conv();
    finish_conv();
    read_strobe_n = 1'b0;
    repeat (6) @(negedge clock);
    cmp_bit("unselected strobe", 1'b0, sample_data_bus_oe);
    cmp_bit("done kept", 1'b0, conversion_done_n);
    read_strobe_n = 1'b1;
    repeat (3) @(negedge clock);
    read_check(4);
    read_word(word);
    cmp_word("over-read", 12'h000, word);
    // Partial reads, then a new trigger restarts the read order
    for (int k = 0; k < 4; k++) begin
      start_conv();
      finish_conv();
      read_check(2);
      start_conv();
      finish_conv();
      read_check(4);
    end
    // Retrigger in mid-conversion with a strobe low
    start_conv();
    repeat (600) @(negedge clock);
    read_strobe_n = 1'b0;
    start_conv();
    finish_conv();
    read_strobe_n = 1'b1;
    read_check(4);
    // Clock pin tied low: internal oscillator
    ext_on = 1'b0;
    conv_clock_pin_off = 1'b1;
    start_conv();
    finish_conv();
    read_check(4);
    give_verdict();
  end
endmodule : tb
